// >>> rtc_gate_regs.vh
// Purpose: Constants for the clock's bus gating and supply reset logic.
// Assumes: One 100 MHz clock; registers reached over a plain strobe port.
// Notes: Offsets are word indexes on the plain register port.
`ifndef RTC_GATE_REGS_VH
`define RTC_GATE_REGS_VH

`define ADDR_W 8
`define DATA_W 8

// Control register: interrupt enables and square wave enable.
`define CTRL_ADDR 8'h0b
`define CTRL_PERIODIC_EN_BIT 6
`define CTRL_ALARM_EN_BIT 5
`define CTRL_UPDATE_EN_BIT 4
`define CTRL_SQW_BIT 3
`define CTRL_RESET 8'h00
`define CTRL_WMASK 8'h78

// Status register: flags, cleared by a read.
`define STAT_ADDR 8'h0c
`define STAT_IRQ_BIT 7
`define STAT_PERIODIC_BIT 6
`define STAT_ALARM_BIT 5
`define STAT_UPDATE_BIT 4

// Latched address readback, gate status.
`define LATCH_ADDR 8'h0d
`define GATE_ADDR 8'h0e
`define GATE_OK_BIT 0
`define GATE_HOLD_BIT 1

`define RAM_WORDS 128

`endif

// >>> rtc_strobe_edge.v
// Purpose: Detects the falling edge of the address strobe.
// Assumes: Strobe input is synchronous to clk.
// Notes: Output is a one-cycle pulse.
`timescale 1ns/100ps
module rtc_strobe_edge (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Strobe
  input wire strobe,
  output wire fall
);

  reg strobe_d;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= strobe;
    end
  end

  assign fall = strobe_d & ~strobe;

endmodule // rtc_strobe_edge

// >>> rtc_bus_gate.v
// Purpose: Address latching, supply gating and supply reset of the clock block.
// Assumes: All inputs synchronous to clk; events arrive as one-cycle pulses.
// Notes: The address latched from the peripheral bus selects the data register.
// Notes on behaviour
// - The falling edge of the address strobe captures the peripheral bus as the address.
// - Supply reset low with test low clears the three interrupt enables.
// - The same condition clears the update, periodic, alarm and summary flags.
// - The same condition clears the square wave enable.
// - While that condition holds, every host read and write is ignored.
// - While supply ok is low, bus activity is ignored, data_out_en stays low and reg_rdata reads zero.
`timescale 1ns/100ps
`include "rtc_gate_regs.vh"
module rtc_bus_gate (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Supply and test
  input wire supply_reset_strobe_n,
  input wire supply_ok,
  input wire test_mode,
  // Address latch
  input wire rtc_addr_latch_strobe,
  input wire [`ADDR_W-1:0] peripheral_data_bus,
  // Register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire data_wr,
  input wire data_rd,
  output reg [`DATA_W-1:0] reg_rdata,
  output reg data_out_en,
  // Timekeeping events
  input wire periodic_event,
  input wire alarm_event,
  input wire update_end_event,
  // Status outputs
  output reg [`ADDR_W-1:0] latched_addr,
  output reg square_wave_enable,
  output reg irq_summary_flag
);

  // ----------------------------------------------------------------
  // Gating
  // ----------------------------------------------------------------
  wire supply_hold;
  wire access_ok;
  wire strobe_fall;
  wire [`ADDR_W-1:0] reg_sel;

  assign supply_hold = ~supply_reset_strobe_n & ~test_mode;
  assign access_ok = supply_ok & ~supply_hold;

  rtc_strobe_edge u_edge (
    .clk(clk),
    .rst(rst),
    .strobe(rtc_addr_latch_strobe),
    .fall(strobe_fall)
  );

  // Data accesses use the latched address; register port uses its own address.
  assign reg_sel = (data_wr | data_rd) ? latched_addr : reg_addr;

  function is_addr;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // True for the fixed register addresses; every other address reaches the RAM.
  function is_fixed;
    input [`ADDR_W-1:0] a;
    begin
      is_fixed = is_addr(a, `CTRL_ADDR) | is_addr(a, `STAT_ADDR) | is_addr(a, `LATCH_ADDR)
        | is_addr(a, `GATE_ADDR);
    end
  endfunction

  // Places the enables at their control register positions; other bits read as zero.
  function [`DATA_W-1:0] pack_ctrl;
    input periodic;
    input alarm;
    input update;
    input square;
    begin
      pack_ctrl = {`DATA_W{1'b0}};
      pack_ctrl[`CTRL_PERIODIC_EN_BIT] = periodic;
      pack_ctrl[`CTRL_ALARM_EN_BIT] = alarm;
      pack_ctrl[`CTRL_UPDATE_EN_BIT] = update;
      pack_ctrl[`CTRL_SQW_BIT] = square;
    end
  endfunction

  // Places the flags at their status register positions; other bits read as zero.
  function [`DATA_W-1:0] pack_status;
    input summary;
    input periodic;
    input alarm;
    input update;
    begin
      pack_status = {`DATA_W{1'b0}};
      pack_status[`STAT_IRQ_BIT] = summary;
      pack_status[`STAT_PERIODIC_BIT] = periodic;
      pack_status[`STAT_ALARM_BIT] = alarm;
      pack_status[`STAT_UPDATE_BIT] = update;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg periodic_irq_enable;
  reg alarm_irq_enable;
  reg update_end_irq_enable;
  reg update_end_flag;
  reg periodic_flag;
  reg alarm_flag;
  reg [`DATA_W-1:0] ram [0:`RAM_WORDS-1];

  wire any_wr;
  wire any_rd;
  wire ctrl_wr;
  wire stat_rd;
  wire ram_wr;
  wire [`DATA_W-1:0] status_word;
  wire [`DATA_W-1:0] ctrl_word;
  wire next_irq;

  assign any_wr = (reg_wr | data_wr) & access_ok;
  assign any_rd = (reg_rd | data_rd) & access_ok;
  assign ctrl_wr = any_wr & is_addr(reg_sel, `CTRL_ADDR);
  assign stat_rd = any_rd & is_addr(reg_sel, `STAT_ADDR);
  assign ram_wr = any_wr & ~is_fixed(reg_sel);
  assign status_word = pack_status(irq_summary_flag, periodic_flag, alarm_flag, update_end_flag);
  assign ctrl_word = pack_ctrl(periodic_irq_enable, alarm_irq_enable, update_end_irq_enable,
    square_wave_enable);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      latched_addr <= 8'h00;
    end else if (strobe_fall & supply_ok) begin
      latched_addr <= peripheral_data_bus;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      periodic_irq_enable <= 1'b0;
      alarm_irq_enable <= 1'b0;
      update_end_irq_enable <= 1'b0;
      square_wave_enable <= 1'b0;
    end else if (supply_hold) begin
      periodic_irq_enable <= 1'b0;
      alarm_irq_enable <= 1'b0;
      update_end_irq_enable <= 1'b0;
      square_wave_enable <= 1'b0;
    end else if (ctrl_wr) begin
      periodic_irq_enable <= reg_wdata[`CTRL_PERIODIC_EN_BIT];
      alarm_irq_enable <= reg_wdata[`CTRL_ALARM_EN_BIT];
      update_end_irq_enable <= reg_wdata[`CTRL_UPDATE_EN_BIT];
      square_wave_enable <= reg_wdata[`CTRL_SQW_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Flags clear on a status read; a same-cycle event still sets its flag.
  assign next_irq = (periodic_irq_enable & (periodic_flag | periodic_event))
    | (alarm_irq_enable & (alarm_flag | alarm_event))
    | (update_end_irq_enable & (update_end_flag | update_end_event));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      periodic_flag <= 1'b0;
      alarm_flag <= 1'b0;
      update_end_flag <= 1'b0;
      irq_summary_flag <= 1'b0;
    end else if (supply_hold) begin
      periodic_flag <= 1'b0;
      alarm_flag <= 1'b0;
      update_end_flag <= 1'b0;
      irq_summary_flag <= 1'b0;
    end else begin
      periodic_flag <= periodic_event | (periodic_flag & ~stat_rd);
      alarm_flag <= alarm_event | (alarm_flag & ~stat_rd);
      update_end_flag <= update_end_event | (update_end_flag & ~stat_rd);
      if (stat_rd) begin
        irq_summary_flag <= (periodic_irq_enable & periodic_event)
          | (alarm_irq_enable & alarm_event)
          | (update_end_irq_enable & update_end_event);
      end else begin
        irq_summary_flag <= next_irq;
      end
    end
  end

  // ----------------------------------------------------------------
  // RAM
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (ram_wr) begin
      ram[reg_sel[6:0]] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      data_out_en <= 1'b0;
    end else begin
      data_out_en <= any_rd & data_rd;
      if (!any_rd) begin
        reg_rdata <= 8'h00;
      end else if (is_addr(reg_sel, `CTRL_ADDR)) begin
        reg_rdata <= ctrl_word;
      end else if (is_addr(reg_sel, `STAT_ADDR)) begin
        reg_rdata <= status_word;
      end else if (is_addr(reg_sel, `LATCH_ADDR)) begin
        reg_rdata <= latched_addr;
      end else if (is_addr(reg_sel, `GATE_ADDR)) begin
        reg_rdata <= {6'h00, supply_hold, supply_ok};
      end else begin
        reg_rdata <= ram[reg_sel[6:0]];
      end
    end
  end

endmodule // rtc_bus_gate

// >>> host_strobe_model.sv
// Purpose: Host side that pulses the address strobe with an address on the bus.
// Assumes: One clock; go is a one-cycle request.
// Notes: After its hold the bus toggles each cycle, showing the inverted and the old address in turn.
`timescale 1ns/100ps
`include "rtc_gate_regs.vh"
module host_strobe_model (
  input wire clk,
  input wire go,
  input wire [`ADDR_W-1:0] addr,
  output reg strobe,
  output reg [`ADDR_W-1:0] bus
);
  reg [1:0] hold_cnt;
  initial begin
    strobe = 1'b0;
    bus = 8'h00;
    hold_cnt = 2'h0;
  end
  always @(posedge clk) begin
    strobe <= go;
    if (go) begin
      bus <= addr;
      hold_cnt <= 2'h3;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end else begin
      bus <= ~bus;
    end
  end
endmodule // host_strobe_model

// >>> rtc_gate_chk.sv
// Purpose: Assertions on address latching and supply gating.
// Assumes: One clock, rst asynchronous and active high.
// Notes: Bound to the gate block below.
`timescale 1ns/100ps
`include "rtc_gate_regs.vh"
module rtc_gate_chk (
  input wire clk,
  input wire rst,
  input wire supply_reset_strobe_n,
  input wire supply_ok,
  input wire test_mode,
  input wire rtc_addr_latch_strobe,
  input wire [`ADDR_W-1:0] peripheral_data_bus,
  input wire reg_wr,
  input wire data_wr,
  input wire [`DATA_W-1:0] reg_rdata,
  input wire data_out_en,
  input wire [`ADDR_W-1:0] latched_addr,
  input wire square_wave_enable,
  input wire irq_summary_flag
);
  wire hold = !supply_reset_strobe_n && !test_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_fall;
    supply_ok && !hold && $fell(rtc_addr_latch_strobe) ##1 supply_ok && $stable(peripheral_data_bus);
  endsequence
  sequence s_quiet;
    hold ##1 (!hold && !reg_wr && !data_wr)[*2];
  endsequence
  property p_latch; s_fall |=> latched_addr == $past(peripheral_data_bus); endproperty
  a_latch: assert property (p_latch) else $error("latched address wrong");
  property p_keep;
    $changed(latched_addr) |-> $past(rtc_addr_latch_strobe, 2) && !$past(rtc_addr_latch_strobe);
  endproperty
  a_keep: assert property (p_keep) else $error("address changed without strobe");
  property p_en; s_quiet |=> !irq_summary_flag; endproperty
  a_en: assert property (p_en) else $error("enable survived supply reset");
  property p_irq; hold |=> !irq_summary_flag; endproperty
  a_irq: assert property (p_irq) else $error("summary flag not cleared");
  property p_sqw; hold |=> !square_wave_enable; endproperty
  a_sqw: assert property (p_sqw) else $error("square wave not cleared");
  property p_blk; hold |=> !data_out_en && reg_rdata == 8'h00; endproperty
  a_blk: assert property (p_blk) else $error("access during supply reset");
  property p_iso; !supply_ok |=> !data_out_en && reg_rdata == 8'h00; endproperty
  a_iso: assert property (p_iso) else $error("bus driven without supply ok");
endmodule // rtc_gate_chk
bind rtc_bus_gate rtc_gate_chk chk_u (.clk, .rst, .supply_reset_strobe_n, .supply_ok,
  .test_mode, .rtc_addr_latch_strobe, .peripheral_data_bus, .reg_wr, .data_wr, .reg_rdata,
  .data_out_en, .latched_addr, .square_wave_enable, .irq_summary_flag);

// >>> testbench.sv
// Purpose: Self-checking bench for the clock block's bus gating.
// Assumes: 100 MHz clock; inputs change by non-blocking assignment at rising edges.
// Notes: Scenarios cover latching, supply reset and supply isolation.
`timescale 1ns/100ps
`include "rtc_gate_regs.vh"
module testbench;
  reg clk = 0, rst = 1, supply_reset_strobe_n = 1, go = 0;
  reg supply_ok = 1, test_mode = 0;
  reg reg_wr = 0, reg_rd = 0, data_wr = 0, data_rd = 0;
  reg periodic_event = 0, alarm_event = 0, update_end_event = 0;
  reg [7:0] pa = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00;
  wire rtc_addr_latch_strobe, data_out_en, square_wave_enable, irq_summary_flag;
  wire [7:0] peripheral_data_bus, reg_rdata, latched_addr;
  integer n_fail = 0, tests_run = 0;
  always #5 clk = ~clk;
  host_strobe_model host_u (.clk, .go, .addr(pa), .strobe(rtc_addr_latch_strobe),
    .bus(peripheral_data_bus));
  rtc_bus_gate dut_u (.clk, .rst, .supply_reset_strobe_n, .supply_ok, .test_mode,
    .rtc_addr_latch_strobe, .peripheral_data_bus, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .data_wr, .data_rd, .reg_rdata, .data_out_en, .periodic_event, .alarm_event,
    .update_end_event, .latched_addr, .square_wave_enable, .irq_summary_flag);
  task chk(input [7:0] got, input [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Access kind k: 8 reg write, 4 reg read, 2 data write, 1 data read.
  task rw(input [3:0] k, input [7:0] a, input [7:0] d);
    @(posedge clk);
    {reg_wr, reg_rd, data_wr, data_rd} <= k;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    {reg_wr, reg_rd, data_wr, data_rd} <= 4'h0;
    #1;
  endtask
  task latch(input [7:0] a);
    @(posedge clk);
    go <= 1;
    pa <= a;
    @(posedge clk);
    go <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task events;
    @(posedge clk);
    {periodic_event, alarm_event, update_end_event} <= 3'h7;
    @(posedge clk);
    {periodic_event, alarm_event, update_end_event} <= 3'h0;
    #1;
  endtask
  task t_latch;
    latch(8'h20);
    chk(latched_addr, 8'h20);
    rw(4'h2, `CTRL_ADDR, 8'h55);
    latch(8'h21);
    rw(4'h2, `CTRL_ADDR, 8'haa);
    latch(8'h20);
    rw(4'h1, `STAT_ADDR, 8'h00);
    chk(reg_rdata, 8'h55);
    chk({7'h00, data_out_en}, 8'h01);
    rw(4'h1, `CTRL_ADDR, 8'h00);
    chk(reg_rdata, 8'h55);
    rw(4'h4, `LATCH_ADDR, 8'h00);
    chk(reg_rdata, 8'h20);
    chk({7'h00, data_out_en}, 8'h00);
  endtask
  task t_hold;
    rw(4'h8, `CTRL_ADDR, 8'h78);
    events;
    chk({6'h00, irq_summary_flag, square_wave_enable}, 8'h03);
    @(posedge clk);
    test_mode <= 1;
    supply_reset_strobe_n <= 0;
    rw(4'h4, `CTRL_ADDR, 8'h00);
    chk(reg_rdata, 8'h78);
    @(posedge clk);
    test_mode <= 0;
    rw(4'h2, 8'h00, 8'h11);
    rw(4'h1, 8'h00, 8'h00);
    chk(reg_rdata, 8'h00);
    rw(4'h4, `GATE_ADDR, 8'h00);
    chk(reg_rdata, 8'h00);
    chk({6'h00, irq_summary_flag, square_wave_enable}, 8'h00);
    @(posedge clk);
    supply_reset_strobe_n <= 1;
    rw(4'h4, `CTRL_ADDR, 8'h00);
    chk(reg_rdata, 8'h00);
    rw(4'h4, `STAT_ADDR, 8'h00);
    chk(reg_rdata, 8'h00);
    rw(4'h4, `GATE_ADDR, 8'h00);
    chk(reg_rdata, 8'h01);
    rw(4'h1, 8'h00, 8'h00);
    chk(reg_rdata, 8'h55);
    events;
    chk({7'h00, irq_summary_flag}, 8'h00);
    rw(4'h8, `CTRL_ADDR, 8'h78);
    rw(4'h4, `STAT_ADDR, 8'h00);
    chk(reg_rdata, 8'hf0);
    rw(4'h4, `STAT_ADDR, 8'h00);
    chk(reg_rdata, 8'h00);
  endtask
  task t_iso;
    @(posedge clk);
    supply_ok <= 0;
    latch(8'h21);
    chk(latched_addr, 8'h20);
    rw(4'h2, 8'h00, 8'h33);
    rw(4'h1, 8'h00, 8'h00);
    chk(reg_rdata, 8'h00);
    chk({7'h00, data_out_en}, 8'h00);
    @(posedge clk);
    supply_ok <= 1;
    rw(4'h1, 8'h00, 8'h00);
    chk(reg_rdata, 8'h55);
  endtask
  task end_sim;
    $display("n_fail %0d tests_run %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_latch;
    t_hold;
    t_iso;
    end_sim;
  end
  initial begin
    #20000;
    n_fail = n_fail + 1;
    end_sim;
  end
endmodule // testbench
